/* tcp_pkg.sv */
// constants shared by the touch controller i2c slave port
package tcp_pkg;
  localparam logic [6:0] ADDR_SEL_LOW = 7'h4C;
  localparam logic [6:0] ADDR_SEL_HIGH = 7'h4D;
  localparam logic COMM_EN_RST = 1'h1;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] TX_LAST = 4'h7;
  localparam logic [3:0] CNT_STEP = 4'h1;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int WORD_W = 2 * DATA_W;
  // one-hot link states
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_CMD = 8'h04,
    ST_WDATA = 8'h08,
    ST_ACK = 8'h10,
    ST_RDATA = 8'h20,
    ST_RACK = 8'h40,
    ST_IGNORE = 8'h80
  } tcp_state_t;
endpackage

/* tcp_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ps
module tcp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // first stage is read by the second stage only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RST;
      q <= RST;
    end else if (en) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // tcp_sync

/* tcp_fifo.sv */
// asynchronous fifo with gray-coded pointers
`timescale 1ns/1ps
module tcp_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic wr_clk,
  input wire logic wr_rst_n,
  input wire logic wr_cke,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_clk,
  input wire logic rd_rst_n,
  input wire logic rd_cke,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [W-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_reg [DEPTH];
  logic [AW:0] wbin_reg, rbin_reg, wgray_reg, rgray_reg;
  logic [AW:0] wgray_s, rgray_s, wbin_next, rbin_next;

  assign wbin_next = wbin_reg + {{AW{1'b0}}, 1'b1};
  assign rbin_next = rbin_reg + {{AW{1'b0}}, 1'b1};
  // full when the far pointer is one lap behind
  assign wr_ready = wgray_reg != {~rgray_s[AW:AW-1], rgray_s[AW-2:0]};
  assign rd_valid = rgray_reg != wgray_s;
  assign rd_data = mem_reg[rbin_reg[AW-1:0]];

  // write side
  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      wbin_reg <= '0;
      wgray_reg <= '0;
    end else if (wr_cke && wr_valid && wr_ready) begin
      wbin_reg <= wbin_next;
      wgray_reg <= wbin_next ^ (wbin_next >> 1);
    end
  end

  // storage, no reset needed
  always_ff @(posedge wr_clk) begin
    if (wr_cke && wr_valid && wr_ready) begin
      mem_reg[wbin_reg[AW-1:0]] <= wr_data;
    end
  end

  // read side
  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      rbin_reg <= '0;
      rgray_reg <= '0;
    end else if (rd_cke && rd_valid && rd_ready) begin
      rbin_reg <= rbin_next;
      rgray_reg <= rbin_next ^ (rbin_next >> 1);
    end
  end

  tcp_sync #(.W(AW + 1)) u_rsync (
    .clk(wr_clk),
    .rst_n(wr_rst_n),
    .en(wr_cke),
    .d(rgray_reg),
    .q(rgray_s)
  );

  tcp_sync #(.W(AW + 1)) u_wsync (
    .clk(rd_clk),
    .rst_n(rd_rst_n),
    .en(rd_cke),
    .d(wgray_reg),
    .q(wgray_s)
  );
endmodule // tcp_fifo

/* tcp_i2c_port.sv */
// i2c slave host port of the rotary touch controller
//
// Behaviour
// R1: address 4C with select low, 4D high
// R2: attention low sets communication enable bit
// R3: open-drain active-low event request output
// R4: data line open-drain, clock line input only
// R5: master makes clock and starts transfers
// R6: start, address, command, data bytes, stop
// R7: start and stop seen with clock high
// R8: one bit per clock, stable while high
// R9: ninth clock carries receiver acknowledge
// R10: eighth address bit chooses write or read
// R11: watch for start plus own address, ack
// R12: first write byte stored as pointer
// R13: data bytes written at auto-incrementing pointer
// R14: reads start at pointer, then increment
// R15: master writes pointer before reading
// R16: master rewrites pointer before verifying
// R17: multi-master hosts use repeated starts
// R18: software reset aborts transfer, restores defaults
// R19: foreign address left unacknowledged, ignored
`timescale 1ns/1ps
module tcp_i2c_port #(
  parameter int FIFO_DEPTH = tcp_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic clk_link,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic slave_addr_select,
  input wire logic attention_in_n,
  input wire logic comm_disable,
  output logic comm_enable_bit,
  input wire logic soft_reset_n,
  input wire logic event_pending,
  output logic irq_n_o,
  output logic irq_n_oe,
  output logic reg_wr_valid,
  input wire logic reg_wr_ready,
  output logic [7:0] reg_wr_addr,
  output logic [7:0] reg_wr_data,
  output logic reg_rd_strobe,
  output logic [7:0] reg_rd_addr,
  input wire logic [7:0] reg_rd_data
);
  // -----------------------------------------------------------------
  // system domain: side pins
  // -----------------------------------------------------------------
  logic attention_in_n_n_s;
  logic comm_en_reg;
  logic irq_reg;

  tcp_sync #(.W(1), .RST(1'b1)) u_attention_in_n_sync (
    .clk(clk_sys),
    .rst_n(reset_n),
    .en(ce),
    .d(attention_in_n),
    .q(attention_in_n_n_s)
  );

  // attention wins over a simultaneous disable or software reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      comm_en_reg <= tcp_pkg::COMM_EN_RST;
    end else if (ce) begin
      if (!attention_in_n_n_s) begin
        comm_en_reg <= 1'b1; // R2
      end else if (!soft_reset_n) begin
        comm_en_reg <= tcp_pkg::COMM_EN_RST; // R18
      end else if (comm_disable) begin
        comm_en_reg <= 1'b0;
      end
    end
  end
  assign comm_enable_bit = comm_en_reg;

  // event request pulls the open-drain line low
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_reg <= 1'b0;
    end else if (ce) begin
      irq_reg <= event_pending; // R3
    end
  end
  assign irq_n_o = 1'b0;
  assign irq_n_oe = irq_reg; // R3

  // -----------------------------------------------------------------
  // system domain: register read service
  // -----------------------------------------------------------------
  logic req_tgl_s, req_prev_reg, ack_tgl_reg, rd_stb_reg;
  logic [7:0] rd_addr_reg, rd_hold_reg;
  logic req_tgl_reg;
  logic [7:0] fetch_addr_reg;

  tcp_sync #(.W(1)) u_req_sync (
    .clk(clk_sys),
    .rst_n(reset_n),
    .en(ce),
    .d(req_tgl_reg),
    .q(req_tgl_s)
  );

  // address is stable in the link domain while the toggle is open
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      req_prev_reg <= 1'b0;
      rd_stb_reg <= 1'b0;
      rd_addr_reg <= tcp_pkg::PTR_RST;
      rd_hold_reg <= '0;
      ack_tgl_reg <= 1'b0;
    end else if (ce) begin
      req_prev_reg <= req_tgl_s;
      rd_stb_reg <= 1'b0;
      if (req_tgl_s != req_prev_reg) begin
        rd_addr_reg <= fetch_addr_reg;
        rd_stb_reg <= 1'b1;
      end
      if (rd_stb_reg) begin
        rd_hold_reg <= reg_rd_data;
        ack_tgl_reg <= ~ack_tgl_reg;
      end
    end
  end
  assign reg_rd_strobe = rd_stb_reg;
  assign reg_rd_addr = rd_addr_reg;

  // -----------------------------------------------------------------
  // link domain: input conditioning
  // -----------------------------------------------------------------
  logic ce_l, srst_n_l, comm_en_l, sel_l, ack_tgl_s;
  logic scl_s, sda_s, scl_d_reg, sda_d_reg;
  logic scl_rise, scl_fall, start_det, stop_det;

  // clock enable has no clock enable of its own
  tcp_sync #(.W(1)) u_ce_sync (
    .clk(clk_link),
    .rst_n(reset_n),
    .en(1'b1),
    .d(ce),
    .q(ce_l)
  );

  tcp_sync #(.W(4), .RST(4'hC)) u_ctl_sync ( // idle levels, no false ack
    .clk(clk_link),
    .rst_n(reset_n),
    .en(ce_l),
    .d({soft_reset_n, comm_en_reg, slave_addr_select, ack_tgl_reg}),
    .q({srst_n_l, comm_en_l, sel_l, ack_tgl_s})
  );

  // idle bus reads high, so lines reset to one
  tcp_sync #(.W(2), .RST(2'h3)) u_bus_sync (
    .clk(clk_link),
    .rst_n(reset_n),
    .en(ce_l),
    .d({scl_i, sda_i}),
    .q({scl_s, sda_s})
  );

  always_ff @(posedge clk_link or negedge reset_n) begin
    if (!reset_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else if (ce_l) begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // clock is only ever sampled, never driven
  assign scl_rise = scl_s && !scl_d_reg; // R4 R8
  assign scl_fall = !scl_s && scl_d_reg;
  assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s; // R7
  assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s; // R7

  // -----------------------------------------------------------------
  // link domain: byte engine
  // -----------------------------------------------------------------
  tcp_pkg::tcp_state_t state_reg, ret_reg;
  logic [7:0] shift_reg, tx_reg, tx_buf_reg, ptr_reg;
  logic [3:0] cnt_reg;
  logic sda_drv_reg, mack_reg, push_reg;
  logic [tcp_pkg::WORD_W-1:0] push_word_reg, pop_word;
  logic fifo_wr_ready;
  logic [6:0] own_addr;

  assign own_addr = sel_l ? tcp_pkg::ADDR_SEL_HIGH : tcp_pkg::ADDR_SEL_LOW; // R1

  always_ff @(posedge clk_link or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= tcp_pkg::ST_IDLE;
      ret_reg <= tcp_pkg::ST_IDLE;
      shift_reg <= '0;
      tx_reg <= '0;
      ptr_reg <= tcp_pkg::PTR_RST;
      cnt_reg <= '0;
      sda_drv_reg <= 1'b0;
      mack_reg <= 1'b0;
      push_reg <= 1'b0;
      push_word_reg <= '0;
    end else if (ce_l) begin
      push_reg <= 1'b0;
      if (!srst_n_l) begin
        // abort and wait for a fresh start
        state_reg <= tcp_pkg::ST_IDLE; // R18
        ptr_reg <= tcp_pkg::PTR_RST; // R18
        sda_drv_reg <= 1'b0;
        cnt_reg <= '0;
      end else if (start_det) begin
        // repeated start restarts address phase from any state
        state_reg <= tcp_pkg::ST_ADDR; // R11
        cnt_reg <= '0;
        sda_drv_reg <= 1'b0;
      end else if (stop_det) begin
        state_reg <= tcp_pkg::ST_IDLE; // R7
        sda_drv_reg <= 1'b0;
      end else begin
        case (state_reg)
          tcp_pkg::ST_ADDR, tcp_pkg::ST_CMD, tcp_pkg::ST_WDATA: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s}; // R8
              cnt_reg <= cnt_reg + tcp_pkg::CNT_STEP;
            end else if (scl_fall && cnt_reg == tcp_pkg::BYTE_BITS) begin
              cnt_reg <= '0;
              state_reg <= tcp_pkg::ST_ACK; // R9
              if (state_reg == tcp_pkg::ST_ADDR) begin
                if (shift_reg[7:1] == own_addr && comm_en_l) begin
                  sda_drv_reg <= 1'b1; // R11
                  ret_reg <= shift_reg[0] ? tcp_pkg::ST_RDATA
                                          : tcp_pkg::ST_CMD; // R10
                end else begin
                  state_reg <= tcp_pkg::ST_IGNORE; // R19
                end
              end else if (state_reg == tcp_pkg::ST_CMD) begin
                ptr_reg <= shift_reg; // R12
                sda_drv_reg <= 1'b1;
                ret_reg <= tcp_pkg::ST_WDATA; // R6
              end else if (fifo_wr_ready) begin
                push_reg <= 1'b1; // R13
                push_word_reg <= {ptr_reg, shift_reg}; // R13
                ptr_reg <= ptr_reg + tcp_pkg::PTR_STEP; // R13
                sda_drv_reg <= 1'b1; // R9
                ret_reg <= tcp_pkg::ST_WDATA;
              end else begin
                // full buffer: refuse the byte with a nack
                ret_reg <= tcp_pkg::ST_IGNORE;
              end
            end
          end
          tcp_pkg::ST_ACK: begin
            if (scl_fall) begin
              state_reg <= ret_reg;
              if (ret_reg == tcp_pkg::ST_RDATA) begin
                tx_reg <= tx_buf_reg; // R14
                sda_drv_reg <= ~tx_buf_reg[7];
              end else begin
                sda_drv_reg <= 1'b0;
              end
            end
          end
          tcp_pkg::ST_RDATA: begin
            // bits change only after the clock falls
            if (scl_fall) begin
              if (cnt_reg == tcp_pkg::TX_LAST) begin
                cnt_reg <= '0;
                sda_drv_reg <= 1'b0;
                state_reg <= tcp_pkg::ST_RACK;
                ptr_reg <= ptr_reg + tcp_pkg::PTR_STEP; // R14
              end else begin
                cnt_reg <= cnt_reg + tcp_pkg::CNT_STEP;
                tx_reg <= {tx_reg[6:0], 1'b0};
                sda_drv_reg <= ~tx_reg[6]; // R8
              end
            end
          end
          tcp_pkg::ST_RACK: begin
            if (scl_rise) begin
              mack_reg <= ~sda_s; // R9
            end else if (scl_fall) begin
              if (mack_reg) begin
                tx_reg <= tx_buf_reg; // R14
                sda_drv_reg <= ~tx_buf_reg[7];
                state_reg <= tcp_pkg::ST_RDATA;
              end else begin
                state_reg <= tcp_pkg::ST_IGNORE;
              end
            end
          end
          default: begin
            // idle and ignore wait for the next start
            sda_drv_reg <= 1'b0; // R19
          end
        endcase
      end
    end
  end

  // only ever pulls low
  assign sda_o = 1'b0; // R4
  assign sda_oe = sda_drv_reg; // R4

  // -----------------------------------------------------------------
  // link domain: read prefetch
  // -----------------------------------------------------------------
  logic ack_prev_reg, stale_reg, busy;

  assign busy = req_tgl_reg != ack_tgl_s;

  // keep tx buffer loaded with the byte at the pointer
  always_ff @(posedge clk_link or negedge reset_n) begin
    if (!reset_n) begin
      req_tgl_reg <= 1'b0;
      fetch_addr_reg <= tcp_pkg::PTR_RST;
      ack_prev_reg <= 1'b0;
      stale_reg <= 1'b1;
      tx_buf_reg <= '0;
    end else if (ce_l) begin
      ack_prev_reg <= ack_tgl_s;
      if (ack_tgl_s != ack_prev_reg) begin
        tx_buf_reg <= rd_hold_reg;
      end
      if (!busy && (stale_reg || fetch_addr_reg != ptr_reg)) begin
        fetch_addr_reg <= ptr_reg; // R14
        req_tgl_reg <= ~req_tgl_reg;
        stale_reg <= push_reg; // a write in this cycle keeps it stale
      end else if (push_reg) begin
        // a write may have changed the prefetched register
        stale_reg <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // write stream to the register array
  // -----------------------------------------------------------------
  tcp_fifo #(.W(tcp_pkg::WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .wr_clk(clk_link),
    .wr_rst_n(reset_n),
    .wr_cke(ce_l),
    .wr_valid(push_reg),
    .wr_ready(fifo_wr_ready),
    .wr_data(push_word_reg),
    .rd_clk(clk_sys),
    .rd_rst_n(reset_n),
    .rd_cke(ce),
    .rd_valid(reg_wr_valid),
    .rd_ready(reg_wr_ready),
    .rd_data(pop_word)
  );
  assign reg_wr_addr = pop_word[15:8];
  assign reg_wr_data = pop_word[7:0];
endmodule // tcp_i2c_port

/* tcp_i2c_port_props.sv */
// assertion checker for the touch controller i2c port
`timescale 1ns/1ps
module tcp_i2c_port_props #(
  parameter int FIFO_DEPTH = tcp_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic clk_link,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic attention_in_n,
  input wire logic comm_disable,
  input wire logic comm_enable_bit,
  input wire logic soft_reset_n,
  input wire logic event_pending,
  input wire logic irq_n_o,
  input wire logic irq_n_oe,
  input wire logic reg_wr_valid,
  input wire logic reg_wr_ready,
  input wire logic [7:0] reg_wr_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_strobe
);
  // stop: data rises while the clock stays high
  sequence s_stop;
    scl_i && $past(scl_i) && $rose(sda_i);
  endsequence
  // soft reset held for two system cycles, beats any disable
  sequence s_srst_held;
    !soft_reset_n [*2];
  endsequence
  // link-domain checks on the wire, then the soft reset enable check on the system clock
  a_sda_held: assert property (@(posedge clk_link)
    disable iff (!reset_n) scl_i && $past(scl_i) |-> $stable(sda_oe))
    else $error("data drive changed while clock high");
  a_stop_free: assert property (@(posedge clk_link)
    disable iff (!reset_n) s_stop |=> !sda_oe [*3])
    else $error("data line driven after stop");
  a_srst_idle: assert property (@(posedge clk_link)
    disable iff (!reset_n) !soft_reset_n [*5] |-> !sda_oe)
    else $error("data line driven in soft reset");
  a_srst_enable: assert property (@(posedge clk_sys)
    disable iff (!reset_n) s_srst_held |-> comm_enable_bit)
    else $error("enable bit not restored by soft reset");
  // system-domain checks
  a_pins_open: assert property (@(posedge clk_sys)
    disable iff (!reset_n) !(sda_oe && sda_o) && !(irq_n_oe && irq_n_o))
    else $error("open-drain pin driven high");
  a_irq_follow: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    irq_n_oe == $past(ce ? event_pending : irq_n_oe))
    else $error("event request not one cycle behind");
  a_attention_in_n_sets: assert property (@(posedge clk_sys)
    disable iff (!reset_n) !attention_in_n [*5] |-> comm_enable_bit)
    else $error("attention did not set enable bit");
  a_rd_pulse: assert property (@(posedge clk_sys)
    disable iff (!reset_n) reg_rd_strobe |=> !reg_rd_strobe)
    else $error("read strobe longer than one cycle");
  a_wr_hold: assert property (@(posedge clk_sys)
    disable iff (!reset_n) reg_wr_valid && !reg_wr_ready |=>
    reg_wr_valid && $stable({reg_wr_addr, reg_wr_data}))
    else $error("write word changed before taken");
endmodule // tcp_i2c_port_props

bind tcp_i2c_port tcp_i2c_port_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
  .clk_sys, .reset_n, .ce, .clk_link, .scl_i, .sda_i, .sda_o, .sda_oe,
  .attention_in_n, .comm_disable, .comm_enable_bit, .soft_reset_n,
  .event_pending, .irq_n_o, .irq_n_oe, .reg_wr_valid, .reg_wr_ready,
  .reg_wr_addr, .reg_wr_data, .reg_rd_strobe);

/* tcp_i2c_master.sv */
// i2c master model that drives the link of the port
`timescale 1ns/1ps
module tcp_i2c_master (
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  int lo_ns = 2400; // clock low time, raised to act as a slow host
  // master owns the clock and starts every transfer
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // one pulse; data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    #200 sda_pull = !b;
    #(lo_ns) scl = 1'b1;
    #800 r = sda;
    scl = 1'b0;
  endtask
  // start or repeated start
  task automatic start();
    #200 sda_pull = 1'b0;
    #(lo_ns) scl = 1'b1;
    #800 sda_pull = 1'b1;
    #800 scl = 1'b0;
  endtask
  // stop leaves both lines high
  task automatic stop();
    #200 sda_pull = 1'b1;
    #(lo_ns) scl = 1'b1;
    #800 sda_pull = 1'b0;
    #800;
  endtask
  // byte out msb first, ninth pulse left free for the ack
  task automatic wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // byte in; master acks all but the last
  task automatic rd(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule // tcp_i2c_master

/* testbench.sv */
// self-checking bench for the touch controller i2c port
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  fails++; $display("Error %0t got %0h exp %0h", $time, a, e); end end
module testbench;
  localparam logic [7:0] AW0 = {tcp_pkg::ADDR_SEL_LOW, 1'b0};
  localparam logic [7:0] AW1 = {tcp_pkg::ADDR_SEL_HIGH, 1'b0};
  localparam logic [7:0] AR1 = {tcp_pkg::ADDR_SEL_HIGH, 1'b1};
  localparam int DEPTH = tcp_pkg::FIFO_DEPTH;
  logic clk_sys, clk_link, reset_n, ce, scl_i, m_pull, slave_addr_select;
  logic attention_in_n, comm_disable, soft_reset_n, event_pending;
  logic reg_wr_ready, sda_o, sda_oe, comm_enable_bit, irq_n_o, irq_n_oe;
  logic reg_wr_valid, reg_rd_strobe;
  logic [7:0] reg_wr_addr, reg_wr_data, reg_rd_addr, reg_rd_data;
  int fails = 0;
  int samples_checked = 0;
  // open-drain data line with pull-up
  wire logic sda_i = !(m_pull || (sda_oe && !sda_o));
  // register file stand-in answers from the address at once
  assign reg_rd_data = reg_rd_addr ^ 8'h5A;
  tcp_i2c_port u_dut (.clk_sys, .reset_n, .ce, .clk_link, .scl_i,
    .sda_i, .sda_o, .sda_oe, .slave_addr_select, .attention_in_n,
    .comm_disable, .comm_enable_bit, .soft_reset_n, .event_pending,
    .irq_n_o, .irq_n_oe, .reg_wr_valid, .reg_wr_ready, .reg_wr_addr,
    .reg_wr_data, .reg_rd_strobe, .reg_rd_addr, .reg_rd_data);
  tcp_i2c_master u_mst (.scl(scl_i), .sda_pull(m_pull), .sda(sda_i));
  // system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = !clk_sys;
  end
  // link clock, phase unrelated to the system clock
  initial begin
    clk_link = 1'b0;
    #37;
    forever #80 clk_link = !clk_link;
  end
  // ---------------------------------------------------------
  // helpers
  // ---------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic tx(input logic [7:0] b, input logic ack);
    logic a;
    u_mst.wr(b, a);
    `CHK(a, ack)
  endtask
  // take one word; ready rises for one cycle so it never pops twice
  task automatic pop(input logic [7:0] a, input logic [7:0] d);
    for (int n = 0; n < 50 && reg_wr_valid !== 1'b1; n++) step(1);
    `CHK({reg_wr_valid, reg_wr_addr, reg_wr_data}, {1'b1, a, d})
    reg_wr_ready = 1'b1;
    step(1);
    reg_wr_ready = 1'b0;
    step(1);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // burst fills the buffer until it refuses, then drains it
  task automatic t_fill();
    u_mst.start();
    tx(AW0, 1'b1);
    tx(8'hFE, 1'b1);
    for (int i = 0; i <= DEPTH; i++) tx(8'(i * 3), 1'(i < DEPTH));
    u_mst.stop();
    for (int i = 0; i < DEPTH; i++) pop(8'(254 + i), 8'(i * 3));
    `CHK(reg_wr_valid, 1'b0)
    $display("fill test done");
  endtask
  // lone command byte sets the pointer, then a slow burst read
  task automatic t_read();
    logic [7:0] b;
    slave_addr_select = 1'b1;
    #1000;
    u_mst.start();
    tx(AW1, 1'b1);
    tx(8'hFF, 1'b1);
    u_mst.stop();
    step(20);
    `CHK(reg_wr_valid, 1'b0)
    u_mst.lo_ns = 4000;
    u_mst.start();
    tx(AR1, 1'b1);
    for (int i = 0; i < 3; i++) begin
      u_mst.rd(1'(i == 2), b);
      `CHK(b, 8'(255 + i) ^ 8'h5A)
    end
    u_mst.stop();
    u_mst.lo_ns = 2400;
    $display("read test done");
  endtask
  // other address ignored; a repeated start reaches this device
  task automatic t_foreign();
    u_mst.start();
    tx(AW0, 1'b0);
    tx(8'h40, 1'b0);
    u_mst.start();
    tx(AW1, 1'b1);
    tx(8'h20, 1'b1);
    tx(8'h77, 1'b1);
    u_mst.stop();
    pop(8'h20, 8'h77);
    $display("foreign test done");
  endtask
  // disable refuses the address; attention enables again
  task automatic t_attention_in_n();
    comm_disable = 1'b1;
    step(1);
    comm_disable = 1'b0;
    step(4);
    `CHK(comm_enable_bit, 1'b0)
    u_mst.start();
    tx(AW1, 1'b0);
    u_mst.stop();
    step(1);
    attention_in_n = 1'b0;
    step(6);
    `CHK(comm_enable_bit, 1'b1)
    attention_in_n = 1'b1;
    u_mst.start();
    tx(AW1, 1'b1);
    tx(8'h30, 1'b1);
    u_mst.stop();
    $display("attention test done");
  endtask
  // soft reset mid-transfer aborts it and restores defaults
  task automatic t_srst();
    logic [7:0] b;
    u_mst.start();
    tx(AW1, 1'b1);
    tx(8'h50, 1'b1);
    step(1);
    comm_disable = 1'b1;
    step(1);
    {comm_disable, soft_reset_n} = 2'h0;
    step(60);
    `CHK({sda_oe, comm_enable_bit}, 2'h1)
    soft_reset_n = 1'b1;
    #1000;
    tx(8'h66, 1'b0);
    u_mst.stop();
    u_mst.start();
    tx(AR1, 1'b1);
    u_mst.rd(1'b1, b);
    `CHK(b, tcp_pkg::PTR_RST ^ 8'h5A)
    u_mst.stop();
    `CHK(reg_wr_valid, 1'b0)
    $display("soft reset test done");
  endtask
  // event request drives the open-drain line one cycle later
  task automatic t_irq();
    step(1);
    event_pending = 1'b1;
    step(1);
    `CHK({irq_n_oe, irq_n_o}, 2'h2)
    event_pending = 1'b0;
    step(1);
    `CHK(irq_n_oe, 1'b0)
    // clock enable low freezes the request output
    ce = 1'b0;
    event_pending = 1'b1;
    step(2);
    `CHK(irq_n_oe, 1'b0)
    {ce, event_pending} = 2'h2;
    step(1);
    $display("event test done");
  endtask
  // main sequence
  initial begin
    {reset_n, slave_addr_select, comm_disable, event_pending} = 4'h0;
    {ce, attention_in_n, soft_reset_n} = 3'h7;
    reg_wr_ready = 1'b0;
    step(5);
    reset_n = 1'b1;
    #1000;
    t_fill();
    t_read();
    t_foreign();
    t_attention_in_n();
    t_srst();
    t_irq();
    summarize();
  end
  // hang guard; the tests need about 1.3 ms
  initial begin
    #3000000;
    fails++;
    summarize();
  end
endmodule // testbench
